//--- core/hppfs_dev.sv
// Purpose: device end, selects the role of the four host port pins
// Assumes: configuration word written by local logic, pins asynchronous
// Notes: pins pass a two-flop synchroniser before any use
// How it works
// RULE1: single strobe, pin A gives transfer direction
// RULE2: dual strobe, pin A is read strobe
// RULE3: single strobe, pin B qualifies each transfer
// RULE4: dual strobe, pin B is write strobe
// RULE5: strobe polarity programmable, active low after reset
// RULE6: single request, pin C is combined request
// RULE7: dual request, pin C is transmit request
// RULE8: dual request, pin D is receive request
// RULE9: single request, pin D is acknowledge input
// RULE10: request and acknowledge polarity programmable, low default
// RULE11: each request output driven or open drain
// RULE12: gpio mode, per-pin direction setting
// RULE13: stop state ignores input pins
// RULE14: stop state holds last output level
// RULE15: wait state changes nothing on the pins; this end has no wait state input, only stop_i
// RULE16: polarity applied before internal strobe logic
`timescale 1ns/1ps
`default_nettype none
module hppfs_dev (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cfg_wr_i,
  input wire logic [15:0] cfg_data_i,
  output logic [15:0] cfg_o,
  input wire logic stop_i,
  input wire logic tx_req_i,
  input wire logic rx_req_i,
  output logic read_cycle_o,
  output logic write_cycle_o,
  output logic read_start_o,
  output logic write_start_o,
  output logic ack_o,
  output logic [3:0] gpio_in_o,
  hppfs_if.dev pins
);
  logic [15:0] cfg_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic read_q;
  logic write_q;
  logic read_start_q;
  logic write_start_q;
  logic ack_q;
  logic [3:0] gpio_in_q;
  logic [3:0] pin_o_q;
  logic [3:0] pin_oe_n_q;
  logic [3:0] pin_o_d;
  logic [3:0] pin_oe_n_d;

  // configuration fields
  wire host_function = cfg_q[hppfs_pkg::F_HOSTFN];
  wire dual_strobe = cfg_q[hppfs_pkg::F_DSTRB];
  wire dual_request = cfg_q[hppfs_pkg::F_DREQ];
  wire strobe_high = cfg_q[hppfs_pkg::F_SPOL];
  wire request_high = cfg_q[hppfs_pkg::F_RPOL];
  wire ack_high = cfg_q[hppfs_pkg::F_APOL];
  wire open_drain = cfg_q[hppfs_pkg::F_OD];
  wire [3:0] gpio_dir = cfg_q[hppfs_pkg::F_DIR +: 4];
  wire [3:0] gpio_out = cfg_q[hppfs_pkg::F_GPO +: 4];

  // inputs are live only in host mode and outside stop
  wire inputs_live = host_function & ~stop_i; // RULE13

  // polarity removed right after the synchroniser
  wire pin_a_act = sync2_q[hppfs_pkg::PIN_A] ^ ~strobe_high; // RULE16
  wire pin_b_act = sync2_q[hppfs_pkg::PIN_B] ^ ~strobe_high; // RULE16
  wire pin_d_act = sync2_q[hppfs_pkg::PIN_D] ^ ~ack_high; // RULE16

  // single strobe roles
  wire read_write_select_in = sync2_q[hppfs_pkg::PIN_A]; // RULE1
  wire data_strobe_in = pin_b_act & ~dual_strobe; // RULE3
  // dual strobe roles
  wire read_strobe_in = pin_a_act & dual_strobe; // RULE2
  wire write_strobe_in = pin_b_act & dual_strobe; // RULE4

  // read select high means read on the single strobe bus
  wire single_read = data_strobe_in & read_write_select_in; // RULE1
  wire single_write = data_strobe_in & ~read_write_select_in; // RULE1
  wire read_d = inputs_live & (single_read | read_strobe_in);
  wire write_d = inputs_live & (single_write | write_strobe_in);

  // one-cycle start pulse at each strobe rise
  wire read_start_d = read_d & ~read_q;
  wire write_start_d = write_d & ~write_q;

  // acknowledge only in single request mode
  wire acknowledge_in = pin_d_act & ~dual_request; // RULE9
  wire ack_d = inputs_live & acknowledge_in; // RULE13

  // request roles, internal active-high
  wire combined_request_out = tx_req_i | rx_req_i; // RULE6
  wire transmit_request_out = tx_req_i; // RULE7
  wire receive_request_out = rx_req_i; // RULE8
  wire req_c_act = dual_request ? transmit_request_out
                                : combined_request_out;
  wire req_c_lvl = req_c_act ^ ~request_high; // RULE10
  wire req_d_lvl = receive_request_out ^ ~request_high; // RULE10

  // open drain releases the pin for a high level
  wire req_c_oe_n = open_drain & req_c_lvl; // RULE11
  wire req_d_oe_n = open_drain & req_d_lvl; // RULE11

  // gpio pins drive when their direction bit is set
  wire [3:0] gpio_oe_n = ~gpio_dir; // RULE12

  // gpio roles, output bits read back as 0
  wire gpio_bit_11 = sync2_q[hppfs_pkg::PIN_A] & ~gpio_dir[hppfs_pkg::PIN_A];
  wire gpio_bit_12 = sync2_q[hppfs_pkg::PIN_B] & ~gpio_dir[hppfs_pkg::PIN_B];
  wire gpio_bit_14 = sync2_q[hppfs_pkg::PIN_C] & ~gpio_dir[hppfs_pkg::PIN_C];
  wire gpio_bit_15 = sync2_q[hppfs_pkg::PIN_D] & ~gpio_dir[hppfs_pkg::PIN_D];
  wire gpio_sample = ~stop_i & ~host_function; // RULE13
  wire [3:0] gpio_in_d = gpio_sample ?
    {gpio_bit_15, gpio_bit_14, gpio_bit_12, gpio_bit_11} : gpio_in_q;

  // pin A and B never driven in host mode
  wire host_oe_a_n = 1'b1;
  wire host_oe_b_n = 1'b1;
  wire host_oe_c_n = req_c_oe_n;
  wire host_oe_d_n = dual_request ? req_d_oe_n : 1'b1;

  // next pin state per role
  always_comb begin
    if (host_function) begin
      pin_o_d = {req_d_lvl, req_c_lvl, 2'b11};
      pin_oe_n_d = {host_oe_d_n, host_oe_c_n, host_oe_b_n, host_oe_a_n};
    end else begin
      pin_o_d = gpio_out; // RULE12
      pin_oe_n_d = gpio_oe_n; // RULE12
    end
  end

  // configuration register
  wire [15:0] cfg_d = cfg_wr_i ? cfg_data_i : cfg_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q <= hppfs_pkg::CFG_RESET; // RULE5
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // two-flop pin synchroniser
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end else begin
      sync1_q <= pins.pin;
      sync2_q <= sync1_q;
    end
  end

  // qualified transfer strobes and their starts
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      read_q <= 1'b0;
      write_q <= 1'b0;
      read_start_q <= 1'b0;
      write_start_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      read_q <= read_d;
      write_q <= write_d;
      read_start_q <= read_start_d;
      write_start_q <= write_start_d;
      ack_q <= ack_d;
    end
  end

  // gpio inputs frozen in stop
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gpio_in_q <= 4'h0;
    end else begin
      gpio_in_q <= gpio_in_d; // RULE13
    end
  end

  // pin drivers hold their last state in stop
  wire [3:0] pin_o_hold = stop_i ? pin_o_q : pin_o_d; // RULE14
  wire [3:0] pin_oe_n_hold = stop_i ? pin_oe_n_q : pin_oe_n_d; // RULE14

  // pin driver registers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_o_q <= 4'hF;
      pin_oe_n_q <= 4'hF;
    end else begin
      pin_o_q <= pin_o_hold; // RULE14
      pin_oe_n_q <= pin_oe_n_hold; // RULE14
    end
  end

  assign pins.dev_o = pin_o_q; // RULE14
  assign pins.dev_oe_n = pin_oe_n_q;
  assign cfg_o = cfg_q;
  assign read_cycle_o = read_q;
  assign write_cycle_o = write_q;
  assign read_start_o = read_start_q;
  assign write_start_o = write_start_q;
  assign ack_o = ack_q;
  assign gpio_in_o = gpio_in_q;
endmodule
`default_nettype wire

//--- core/hppfs_host.sv
// Purpose: host end, drives strobes and acknowledge, watches requests
// Assumes: software reaches the controller registers over APB
// Notes: strobe pulses last a fixed number of clock cycles
`timescale 1ns/1ps
`default_nettype none
module hppfs_host (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  hppfs_if.host pins
);
  hppfs_pkg::hppfs_state_t state_q;
  hppfs_pkg::hppfs_state_t state_d;
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  logic read_op_q;
  logic ack_op_q;
  logic [3:0] cnt_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] pin_o_q;
  logic [3:0] pin_oe_n_q;
  logic [3:0] pin_o_d;

  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i;
  wire hit_ctrl = paddr_i == hppfs_pkg::OFS_CTRL;
  wire hit_cmd = paddr_i == hppfs_pkg::OFS_CMD;
  wire hit_stat = paddr_i == hppfs_pkg::OFS_STAT;
  wire mapped = hit_ctrl | hit_cmd | hit_stat;
  wire ctrl_wr = access & pwrite_i & hit_ctrl;
  wire idle = state_q == hppfs_pkg::HS_IDLE;
  wire cmd_go = access & pwrite_i & hit_cmd & idle;

  wire enable = ctrl_q[hppfs_pkg::F_HOSTFN];
  wire dual_strobe = ctrl_q[hppfs_pkg::F_DSTRB];
  wire dual_request = ctrl_q[hppfs_pkg::F_DREQ];
  wire strobe_high = ctrl_q[hppfs_pkg::F_SPOL];
  wire request_high = ctrl_q[hppfs_pkg::F_RPOL];
  wire ack_high = ctrl_q[hppfs_pkg::F_APOL];

  // requests seen active-high
  wire req_c = sync2_q[hppfs_pkg::PIN_C] ^ ~request_high; // RULE10
  wire req_d = dual_request & (sync2_q[hppfs_pkg::PIN_D] ^ ~request_high);
  wire [31:0] stat = {29'h0, req_d, req_c, ~idle};
  wire [31:0] rdata = hit_ctrl ? ctrl_q : (hit_stat ? stat : 32'h0);

  wire pulse = state_q == hppfs_pkg::HS_STRB;
  wire strobe_on = pulse & ~ack_op_q;
  wire ack_on = pulse & ack_op_q;
  wire cnt_done = cnt_q == 4'h0;
  // level driven on pins A, B, D
  wire pin_a = dual_strobe ? (strobe_on & read_op_q) ^ ~strobe_high // RULE2
                           : read_op_q; // RULE1
  wire pin_b = dual_strobe ? (strobe_on & ~read_op_q) ^ ~strobe_high // RULE4
                           : strobe_on ^ ~strobe_high; // RULE3
  wire pin_d = ack_on ^ ~ack_high; // RULE9
  wire [3:0] oe_n_d = {~enable | dual_request, 1'b1, ~enable, ~enable};

  always_comb begin
    pin_o_d = {pin_d, 1'b1, pin_b, pin_a};
    case (state_q)
      hppfs_pkg::HS_IDLE: state_d = cmd_go ? hppfs_pkg::HS_SETUP
                                           : hppfs_pkg::HS_IDLE;
      hppfs_pkg::HS_SETUP: state_d = hppfs_pkg::HS_STRB;
      hppfs_pkg::HS_STRB: state_d = cnt_done ? hppfs_pkg::HS_HOLD
                                             : hppfs_pkg::HS_STRB;
      hppfs_pkg::HS_HOLD: state_d = hppfs_pkg::HS_IDLE;
      default: state_d = hppfs_pkg::HS_IDLE;
    endcase
  end

  // next values of the control, command and counter registers
  wire [31:0] ctrl_d = ctrl_wr ? pwdata_i : ctrl_q;
  wire [31:0] prdata_d = setup ? rdata : prdata_q;
  wire read_op_d = cmd_go ? pwdata_i[hppfs_pkg::CMD_READ] : read_op_q;
  wire ack_op_d = cmd_go ? pwdata_i[hppfs_pkg::CMD_ACK] : ack_op_q;
  wire [3:0] cnt_d = pulse ? cnt_q - 4'h1 : hppfs_pkg::STRB_CNT;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= hppfs_pkg::CTRL_RESET;
      prdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= hppfs_pkg::HS_IDLE;
      read_op_q <= 1'b0;
      ack_op_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      read_op_q <= read_op_d;
      ack_op_q <= ack_op_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      pin_o_q <= 4'hF;
      pin_oe_n_q <= 4'hF;
    end else begin
      sync1_q <= pins.pin;
      sync2_q <= sync1_q;
      pin_o_q <= pin_o_d;
      pin_oe_n_q <= oe_n_d;
    end
  end

  assign pins.host_o = pin_o_q;
  assign pins.host_oe_n = pin_oe_n_q;
  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~mapped;
endmodule
`default_nettype wire

//--- core/hppfs_if.sv
// Purpose: the four shared control pins between device and host
// Assumes: an undriven pin is pulled up
// Notes: each end drives a pin only while its enable (low) is asserted
`timescale 1ns/1ps
`default_nettype none
interface hppfs_if;
  logic [3:0] dev_o;
  logic [3:0] dev_oe_n;
  logic [3:0] host_o;
  logic [3:0] host_oe_n;
  logic [3:0] pin;
  // resolved wire level, pull-up when released
  assign pin = (~dev_oe_n & dev_o)
             | (dev_oe_n & ~host_oe_n & host_o)
             | (dev_oe_n & host_oe_n);
  modport dev (input pin, output dev_o, output dev_oe_n);
  modport host (input pin, output host_o, output host_oe_n);
endinterface
`default_nettype wire

//--- core/hppfs_pkg.sv
// Purpose: shared constants for the host port pin function select ends
// Assumes: pin index order A, B, C, D on a four-bit pin vector
// Notes: 125 MHz clock, one aligned 32-bit word per host register
package hppfs_pkg;
  // pin indices on the shared vector
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;
  localparam int NPIN = 4;
  // device configuration word fields
  localparam int CFG_W = 16;
  localparam int F_HOSTFN = 0;
  localparam int F_DSTRB = 1;
  localparam int F_DREQ = 2;
  localparam int F_SPOL = 3;
  localparam int F_RPOL = 4;
  localparam int F_APOL = 5;
  localparam int F_OD = 6;
  localparam int F_DIR = 8;
  localparam int F_GPO = 12;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // host controller register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CMD_READ = 0;
  localparam int CMD_ACK = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_REQC = 1;
  localparam int ST_REQD = 2;
  // strobe timing
  localparam int CLK_NS = 8;
  localparam int STRB_NS = 40;
  localparam int STRB_CYC = (STRB_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STRB_CNT = 4'(STRB_CYC - 1);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SETUP = 2'b01,
    HS_STRB = 2'b11,
    HS_HOLD = 2'b10
  } hppfs_state_t;
endpackage

//--- sim/host_port_pin_function_select_tb.sv
// Purpose: drives both ends through config and APB, checks pin roles
// Assumes: host registers one aligned word each
// Notes: counts strobe cycles seen by the device end
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_function_select_tb;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, rc, wc, rs, ws, ack;
  logic cfg_wr = 1'b0, stop = 1'b0, tx = 1'b0, rx = 1'b0;
  logic [15:0] cfg_data = 16'h0000, cfg_q;
  logic [3:0] gin;
  int n_fail = 0, checks = 0, n_ws = 0, n_rs = 0, n_wc = 0, n_ack = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  hppfs_if u_if();
  hppfs_dev u_hppfs_dev(.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .cfg_wr_i(cfg_wr), .cfg_data_i(cfg_data), .cfg_o(cfg_q),
    .stop_i(stop), .tx_req_i(tx), .rx_req_i(rx), .read_cycle_o(rc),
    .write_cycle_o(wc), .read_start_o(rs), .write_start_o(ws),
    .ack_o(ack), .gpio_in_o(gin), .pins(u_if.dev));
  hppfs_host u_hppfs_host(.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pins(u_if.host));
  hppfs_monitor u_hppfs_monitor(.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .dev_o(u_if.dev_o), .dev_oe_n(u_if.dev_oe_n),
    .host_o(u_if.host_o), .host_oe_n(u_if.host_oe_n), .pin(u_if.pin));
  always @(posedge ref_clk_i) begin
    n_ws <= n_ws + int'(ws);
    n_rs <= n_rs + int'(rs);
    n_wc <= n_wc + int'(wc);
    n_ack <= n_ack + int'(ack);
  end
  task automatic wrap_up();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, hppfs_pkg::OFS_CMD, c);
    do apb(1'b0, hppfs_pkg::OFS_STAT, 32'h0); while (q[0] !== 1'b0);
  endtask
  task automatic setup(input logic [15:0] c, input logic [31:0] k);
    apb(1'b1, hppfs_pkg::OFS_CTRL, 32'h0);
    cyc(4);
    cfg_wr <= 1'b1;
    cfg_data <= c;
    @(posedge ref_clk_i);
    cfg_wr <= 1'b0;
    cyc(2);
    apb(1'b1, hppfs_pkg::OFS_CTRL, k);
    cyc(4);
  endtask
  initial begin
    cyc(6);
    arst_n_i <= 1'b1;
    cyc(2);
    chk(32'(cfg_q), 32'(hppfs_pkg::CFG_RESET));
    apb(1'b0, hppfs_pkg::OFS_CTRL, 32'h0);
    chk(q, hppfs_pkg::CTRL_RESET);
    chk(32'(u_if.pin), 32'hF);
    apb(1'b0, 8'h0C, 32'h0);
    chk({q[30:0], err}, 32'h1);
    // gpio directions, then stop holds drive
    setup(16'h0500, 32'h0);
    chk(32'(u_if.pin), 32'hA);
    chk(32'(gin), 32'hA);
    stop <= 1'b1;
    cfg_wr <= 1'b1;
    cfg_data <= 16'h0000;
    cyc(1);
    cfg_wr <= 1'b0;
    cyc(4);
    chk(32'(u_if.pin), 32'hA);
    chk(32'(gin), 32'hA);
    stop <= 1'b0;
    // single strobe, single request
    setup(16'h0001, 32'h1);
    cmd(32'h0);
    cmd(32'h1);
    cyc(4);
    chk(n_ws, 1);
    chk(n_rs, 1);
    chk(n_wc, hppfs_pkg::STRB_CYC);
    cmd(32'h2);
    cyc(4);
    chk(n_ack, hppfs_pkg::STRB_CYC);
    tx <= 1'b1;
    cyc(4);
    chk(32'(u_if.pin[2]), 32'h0);
    apb(1'b0, hppfs_pkg::OFS_STAT, 32'h0);
    chk(32'(q[1]), 32'h1);
    tx <= 1'b0;
    rx <= 1'b1;
    cyc(4);
    chk(32'(u_if.pin[2]), 32'h0);
    rx <= 1'b0;
    // dual strobe
    setup(16'h0003, 32'h3);
    cmd(32'h0);
    cmd(32'h1);
    cyc(4);
    chk(n_ws, 2);
    chk(n_rs, 2);
    stop <= 1'b1;
    cmd(32'h0);
    cyc(4);
    chk(n_ws, 2);
    tx <= 1'b1;
    cyc(4);
    chk(32'(u_if.pin[2]), 32'h1);
    stop <= 1'b0;
    cyc(4);
    chk(32'(u_if.pin[2]), 32'h0);
    tx <= 1'b0;
    // dual request, driven then open drain
    setup(16'h0007, 32'h7);
    tx <= 1'b1;
    cyc(4);
    chk(32'(u_if.pin[3:2]), 32'h2);
    apb(1'b0, hppfs_pkg::OFS_STAT, 32'h0);
    chk(32'(q[2:1]), 32'h1);
    tx <= 1'b0;
    rx <= 1'b1;
    cyc(4);
    chk(32'(u_if.pin[3:2]), 32'h1);
    rx <= 1'b0;
    setup(16'h0047, 32'h7);
    chk(32'(u_if.dev_oe_n[3:2]), 32'h3);
    tx <= 1'b1;
    cyc(4);
    chk(32'({u_if.dev_oe_n[2], u_if.pin[2]}), 32'h0);
    tx <= 1'b0;
    // device polarities high, host strobes low, host requests high
    setup(16'h003B, 32'h13);
    chk(32'({rc, wc, ack, u_if.pin[2]}), 32'hE);
    apb(1'b0, hppfs_pkg::OFS_STAT, 32'h0);
    chk(32'(q[2:1]), 32'h0);
    tx <= 1'b1;
    cyc(4);
    apb(1'b0, hppfs_pkg::OFS_STAT, 32'h0);
    chk(32'({u_if.pin[2], q[1]}), 32'h3);
    tx <= 1'b0;
    wrap_up();
  end
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire

//--- sim/hppfs_monitor.sv
// Purpose: pin level checks on the shared host port pins
// Assumes: strobes and acknowledge pulsed at their default low level
// Notes: sees only the interface signals, clock and reset
`timescale 1ns/1ps
`default_nettype none
module hppfs_monitor (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe_n,
  input wire logic [3:0] host_o,
  input wire logic [3:0] host_oe_n,
  input wire logic [3:0] pin
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_reset_release: assert property (
    $rose(arst_n_i) |-> dev_oe_n == 4'hF && host_oe_n == 4'hF)
    else $error("pin drivers on after reset");
  a_no_contention: assert property (
    (dev_oe_n | host_oe_n) == 4'hF)
    else $error("both ends drive one pin");
  a_req_dev_only: assert property (
    host_oe_n[2]) else $error("host drives request pin");
  a_release_high: assert property (
    dev_oe_n[2] && host_oe_n[2] |-> pin[2])
    else $error("released request pin not high");
  a_strobe_width: assert property (
    $fell(host_o[1]) && !host_oe_n[1] && $stable(host_oe_n[1])
    |-> (!host_o[1])[*5] ##1 host_o[1])
    else $error("data strobe width wrong");
  a_strobe_gap: assert property (
    $rose(host_o[1]) && !host_oe_n[1] && $stable(host_oe_n[1])
    |-> host_o[1][*3]) else $error("strobes too close");
  a_dir_steady: assert property (
    $fell(host_o[1]) && !host_oe_n[1] |-> $stable(host_o[0])[*5])
    else $error("direction moved in strobe");
  a_ack_width: assert property (
    $fell(host_o[3]) && !host_oe_n[3] && $stable(host_oe_n[3])
    |-> (!host_o[3])[*5] ##1 host_o[3])
    else $error("acknowledge width wrong");
  c_strobe: cover property ($fell(host_o[1]) && !host_oe_n[1]);
  c_req: cover property (!dev_oe_n[2] && !pin[2]);
  c_ack: cover property ($fell(host_o[3]) && !host_oe_n[3]);
endmodule
`default_nettype wire
